// file: rtl/mio_dev.sv
// Purpose: Flash device end, multi-line page write and OTP areas
// Assumes: Link pins sampled by clk_sys_i, serial clock much slower
// Notes: Lock bits, protect field, quad enable are plain inputs
//
// Added by the designer: the register addresses and the APB register port.
`timescale 1ns/1ns
module mio_dev #(
   parameter int MAIN_AW = 10,
   parameter int SE_TIME_NS = 4000,
   parameter int PP_TIME_NS = 1000
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [mio_pkg::AREA_CNT-1:0] otp_area_lock_bits_i,
   input wire logic [4:0] protect_field_i,
   input wire logic quad_lines_enable_i,
   output logic busy_flag_o,
   output logic write_enable_latch_o,
   mio_if.dev lnk
);
   import mio_pkg::*;
   localparam int SE_CYC = (SE_TIME_NS + CLK_NS - 1) / CLK_NS;
   localparam int PP_CYC = (PP_TIME_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [2:0] {
      ST_OP, ST_ADR, ST_DMY, ST_DAT, ST_OUT, ST_IGN
   } mio_dst_t;
   typedef struct packed {
      logic [5:0] s1;
      logic [5:0] s2;
      logic sck_p;
      logic cs_p;
      mio_dst_t st;
      logic [7:0] opc;
      logic [7:0] sr;
      logic [3:0] bc;
      logic [1:0] ac;
      logic [23:0] adr;
      logic got;
      logic [7:0] osh;
      logic [2:0] oc;
      logic so;
      logic oe;
      logic busy;
      logic write_enable_latch;
      logic erase;
      logic [1:0] era;
      logic [19:0] tmr;
      logic [PAGE_BYTES-1:0] pv;
   } mio_dev_t;
   mio_dev_t s_q, s_d;
   logic [7:0] main_m [2**MAIN_AW];
   logic [7:0] pbuf_m [PAGE_BYTES];
   logic [7:0] sec_m [AREA_CNT][AREA_BYTES];
   logic sck, csn, rise, fall, cs_up, prot, aok;
   logic [3:0] io, bcn;
   logic [2:0] w;
   logic [7:0] sh, ob;
   logic [23:0] an;
   logic [1:0] ar;
   logic pb_we, sec_we, commit, fill;
   logic [7:0] pb_dat;
   function automatic logic adr_ok(input logic [23:0] a);
      adr_ok = a[23:16] == AREA_HI && a[11:10] == 2'b00 &&
               a[15:12] >= AREA_SEL_MIN && a[15:12] <= AREA_SEL_MAX;
   endfunction
   function automatic logic [1:0] area_of(input logic [23:0] a);
      area_of = 2'(a[13:12] - 2'h1);
   endfunction

   // ****************************************
   // Command decode
   // ****************************************
   always_comb begin
      s_d = s_q;
      pb_we = 1'b0;
      sec_we = 1'b0;
      commit = 1'b0;
      fill = 1'b0;
      s_d.s1 = {lnk.io, lnk.cs_n, lnk.sclk};
      s_d.s2 = s_q.s1;
      sck = s_q.s2[0];
      csn = s_q.s2[1];
      io = s_q.s2[5:2];
      s_d.sck_p = sck;
      s_d.cs_p = csn;
      rise = sck & ~s_q.sck_p & ~csn;
      fall = ~sck & s_q.sck_p & ~csn;
      cs_up = csn & ~s_q.cs_p;
      prot = protect_field_i != 5'h00;
      ar = area_of(s_q.adr);
      aok = adr_ok(s_q.adr) && !otp_area_lock_bits_i[ar];
      w = 3'h1;
      if (s_q.st == ST_DAT && s_q.opc == OP_TWO_LINE_WR) w = 3'h2;
      if (s_q.st == ST_DAT && s_q.opc == OP_FOUR_LINE_WR) w = 3'h4;
      case (w)
         3'h4: sh = {s_q.sr[3:0], io};
         3'h2: sh = {s_q.sr[5:0], io[1:0]};
         default: sh = {s_q.sr[6:0], io[0]};
      endcase
      pb_dat = sh;
      bcn = s_q.bc + 4'(w);
      an = {s_q.adr[15:0], sh};
      ob = sec_m[ar][s_q.adr[9:0]];
      if (s_q.opc == OP_RDSR) begin
         ob = 8'h00;
         ob[ST_BUSY_BIT] = s_q.busy;
         ob[ST_WEL_BIT] = s_q.write_enable_latch;
      end
      if (s_q.busy) begin
         if (s_q.tmr == 20'h0) begin
            s_d.busy = 1'b0;
            s_d.write_enable_latch = 1'b0;
            fill = s_q.erase;
         end else begin
            s_d.tmr = s_q.tmr - 20'h1;
         end
      end
      if (rise && s_q.st != ST_OUT) begin
         s_d.sr = sh;
         s_d.bc = bcn;
         if (s_q.st == ST_IGN) s_d.got = 1'b1;
      end
      if (rise && bcn == 4'h8) begin
         s_d.bc = 4'h0;
         case (s_q.st)
            ST_OP: begin
               s_d.opc = sh;
               s_d.ac = 2'h0;
               s_d.st = ST_IGN;
               s_d.got = 1'b1;
               if (sh == OP_WREN) begin
                  s_d.got = 1'b0;
               end else if (sh == OP_RDSR) begin
                  s_d.st = ST_OUT;
                  s_d.oc = 3'h0;
               end else if (s_q.busy) begin
                  s_d.st = ST_IGN;
               end else if (sh == OP_OTP_READ) begin
                  s_d.st = ST_ADR;
               end else if (sh == OP_FOUR_LINE_WR) begin
                  if (s_q.write_enable_latch && quad_lines_enable_i) s_d.st = ST_ADR;
               end else if (sh == OP_TWO_LINE_WR || sh == OP_PAGE_WR ||
                            sh == OP_OTP_ERASE || sh == OP_OTP_WRITE) begin
                  if (s_q.write_enable_latch) s_d.st = ST_ADR;
               end
            end
            ST_ADR: begin
               s_d.adr = an;
               s_d.ac = s_q.ac + 2'h1;
               if (s_q.ac == 2'h2) begin
                  s_d.st = ST_IGN;
                  if (s_q.opc == OP_OTP_ERASE) begin
                     s_d.got = 1'b0;
                  end else if (s_q.opc == OP_OTP_READ) begin
                     if (adr_ok(an)) s_d.st = ST_DMY;
                  end else if (s_q.opc == OP_OTP_WRITE) begin
                     if (adr_ok(an) &&
                         !otp_area_lock_bits_i[area_of(an)]) begin
                        s_d.st = ST_DAT;
                     end
                  end else if (!prot) begin
                     s_d.st = ST_DAT;
                     s_d.pv = '0;
                  end
               end
            end
            ST_DMY: begin
               s_d.st = ST_OUT;
               s_d.oc = 3'h0;
            end
            ST_DAT: begin
               s_d.got = 1'b1;
               if (s_q.opc == OP_OTP_WRITE) begin
                  sec_we = 1'b1;
                  s_d.adr[9:0] = s_q.adr[9:0] + 10'h1;
               end else begin
                  pb_we = 1'b1;
                  s_d.pv[s_q.adr[7:0]] = 1'b1;
                  s_d.adr[7:0] = s_q.adr[7:0] + 8'h1;
               end
            end
            default: s_d.st = ST_IGN;
         endcase
      end
      if (fall && s_q.st == ST_OUT) begin
         s_d.oe = 1'b1;
         if (s_q.oc == 3'h0) begin
            s_d.so = ob[7];
            s_d.osh = {ob[6:0], 1'b0};
            s_d.oc = 3'h7;
            if (s_q.opc == OP_OTP_READ) begin
               s_d.adr[9:0] = s_q.adr[9:0] + 10'h1;
            end
         end else begin
            s_d.so = s_q.osh[7];
            s_d.osh = {s_q.osh[6:0], 1'b0};
            s_d.oc = s_q.oc - 3'h1;
         end
      end
      if (cs_up) begin
         if (s_q.st == ST_IGN && !s_q.got && !s_q.busy) begin
            if (s_q.opc == OP_WREN) begin
               s_d.write_enable_latch = 1'b1;
            end else if (s_q.opc == OP_OTP_ERASE && aok) begin
               s_d.busy = 1'b1;
               s_d.erase = 1'b1;
               s_d.era = ar;
               s_d.tmr = 20'(SE_CYC - 1);
            end
         end
         if (s_q.st == ST_DAT && s_q.got && s_q.bc == 4'h0) begin
            s_d.busy = 1'b1;
            s_d.erase = 1'b0;
            s_d.tmr = 20'(PP_CYC - 1);
            commit = s_q.opc != OP_OTP_WRITE;
         end
         s_d.st = ST_OP;
         s_d.bc = 4'h0;
         s_d.oe = 1'b0;
         s_d.got = 1'b0;
      end
   end

   // ****************************************
   // State and storage
   // ****************************************
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.s1 <= 6'h3e;
         s_q.s2 <= 6'h3e;
         s_q.cs_p <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (pb_we) pbuf_m[s_q.adr[7:0]] <= pb_dat;
      if (sec_we) begin
         sec_m[ar][s_q.adr[9:0]] <= sec_m[ar][s_q.adr[9:0]] & pb_dat;
      end
      if (commit) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (s_q.pv[i]) begin
               main_m[{s_q.adr[MAIN_AW-1:8], 8'(i)}] <=
                  main_m[{s_q.adr[MAIN_AW-1:8], 8'(i)}] & pbuf_m[i];
            end
         end
      end
      if (fill) begin
         for (int j = 0; j < AREA_BYTES; j++) begin
            sec_m[s_q.era][j] <= ERASED;
         end
      end
   end

   assign busy_flag_o = s_q.busy;
   assign write_enable_latch_o = s_q.write_enable_latch;
   assign lnk.d_io = {2'b00, s_q.so, 1'b0};
   assign lnk.d_oe = {2'b00, s_q.oe, 1'b0};
endmodule

// file: rtl/mio_host.sv
// Purpose: Host serial controller driven from APB registers
// Assumes: Software feeds one byte per WDATA write
// Notes: Serial clock stalls while a data byte is awaited
`timescale 1ns/1ns
module mio_host (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic [7:0] paddr_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   mio_if.host lnk
);
   import mio_pkg::*;
   typedef enum logic [2:0] {
      H_IDLE, H_LOW, H_HIGH, H_WAIT, H_END
   } mio_hst_t;
   typedef enum logic [1:0] {SG_OP, SG_AD, SG_DM, SG_DT} mio_seg_t;
   typedef struct packed {
      logic s1;
      logic s2;
      mio_hst_t st;
      mio_seg_t seg;
      logic [3:0] tc;
      logic sck;
      logic csn;
      logic [4:0] bl;
      logic [23:0] tx;
      logic [2:0] w;
      logic [11:0] nb;
      logic [7:0] rx;
      logic wd_full;
      logic [7:0] wd;
      logic rd_full;
      logic [7:0] rd;
      logic [7:0] opc;
      logic [23:0] adr;
      logic [11:0] len;
      logic [3:0] io;
      logic [3:0] oe;
      logic rdy;
      logic [31:0] prd;
      logic err;
   } mio_host_t;
   mio_host_t s_q, s_d;
   logic tick, rdop, wrop, ld, done, acc;
   logic [7:0] rx_n;

   // ****************************************
   // APB registers and link sequencer
   // ****************************************
   always_comb begin
      s_d = s_q;
      ld = 1'b0;
      done = 1'b0;
      s_d.s1 = lnk.io[1];
      s_d.s2 = s_q.s1;
      acc = psel_i & penable_i;
      rdop = s_q.opc == OP_RDSR || s_q.opc == OP_OTP_READ;
      wrop = s_q.opc == OP_PAGE_WR || s_q.opc == OP_TWO_LINE_WR ||
             s_q.opc == OP_FOUR_LINE_WR || s_q.opc == OP_OTP_WRITE;
      rx_n = {s_q.rx[6:0], s_q.s2};
      tick = s_q.tc == SCLK_HALF_CYC - 4'h1;
      s_d.tc = tick ? 4'h0 : s_q.tc + 4'h1;
      s_d.rdy = 1'b0;
      if (acc && !s_q.rdy &&
          !(pwrite_i && paddr_i == REG_WDATA && s_q.wd_full)) begin
         s_d.rdy = 1'b1;
         s_d.err = 1'b0;
         case (paddr_i)
            REG_CTRL: s_d.prd = {24'h0, s_q.opc};
            REG_ADDR: s_d.prd = {8'h0, s_q.adr};
            REG_LEN: s_d.prd = {20'h0, s_q.len};
            REG_WDATA: s_d.prd = {24'h0, s_q.wd};
            REG_RDATA: s_d.prd = {24'h0, s_q.rd};
            REG_STAT: s_d.prd = {29'h0, s_q.rd_full, s_q.wd_full,
                                 s_q.st != H_IDLE};
            default: begin
               s_d.prd = 32'h0;
               s_d.err = 1'b1;
            end
         endcase
      end
      if (acc && s_q.rdy && pwrite_i) begin
         case (paddr_i)
            REG_CTRL: begin
               if (s_q.st == H_IDLE) s_d.opc = pwdata_i[7:0];
               if (s_q.st == H_IDLE && pwdata_i[CTRL_GO_BIT]) begin
                  s_d.st = H_LOW;
                  s_d.tc = 4'h0;
                  s_d.csn = 1'b0;
                  s_d.seg = SG_OP;
                  s_d.bl = 5'd8;
                  s_d.w = 3'h1;
                  s_d.tx = {pwdata_i[7:0], 16'h0};
                  s_d.nb = s_q.len;
               end
            end
            REG_ADDR: s_d.adr = pwdata_i[23:0];
            REG_LEN: s_d.len = pwdata_i[11:0];
            REG_WDATA: begin
               s_d.wd = pwdata_i[7:0];
               s_d.wd_full = 1'b1;
            end
            default: s_d.err = s_q.err;
         endcase
      end
      if (acc && s_q.rdy && !pwrite_i && paddr_i == REG_RDATA) begin
         s_d.rd_full = 1'b0;
      end
      case (s_q.st)
         H_LOW: if (tick) begin
            s_d.st = H_HIGH;
            s_d.sck = 1'b1;
            s_d.bl = 5'(s_q.bl - {2'b00, s_q.w});
            if (s_q.seg == SG_DT && rdop) begin
               s_d.rx = rx_n;
               if (s_q.bl == 5'd1) begin
                  s_d.rd = rx_n;
                  s_d.rd_full = 1'b1;
               end
            end
         end
         H_HIGH: if (tick && !(s_q.seg == SG_DT && rdop && s_q.rd_full &&
                               s_q.nb != 12'h1)) begin
            s_d.st = H_LOW;
            s_d.sck = 1'b0;
            s_d.tx = s_q.tx << s_q.w;
            if (s_q.bl == 5'd0) begin
               s_d.bl = 5'd8;
               case (s_q.seg)
                  SG_OP: begin
                     if (s_q.opc == OP_WREN) begin
                        done = 1'b1;
                     end else if (s_q.opc == OP_RDSR) begin
                        s_d.seg = SG_DT;
                     end else begin
                        s_d.seg = SG_AD;
                        s_d.bl = 5'd24;
                        s_d.tx = s_q.adr;
                     end
                  end
                  SG_AD: begin
                     if (s_q.opc == OP_OTP_READ) begin
                        s_d.seg = SG_DM;
                        s_d.tx = 24'h0;
                     end else if (wrop && s_q.nb != 12'h0) begin
                        s_d.seg = SG_DT;
                        ld = 1'b1;
                     end else begin
                        done = 1'b1;
                     end
                  end
                  SG_DM: s_d.seg = SG_DT;
                  default: begin
                     s_d.nb = s_q.nb - 12'h1;
                     if (s_q.nb <= 12'h1) done = 1'b1;
                     else ld = wrop;
                  end
               endcase
            end
         end
         H_WAIT: if (s_q.wd_full) begin
            s_d.st = H_LOW;
            s_d.tc = 4'h0;
            s_d.tx = {s_q.wd, 16'h0};
            s_d.wd_full = 1'b0;
         end
         H_END: if (tick) s_d.st = H_IDLE;
         default: s_d.tc = 4'h0;
      endcase
      if (ld) begin
         s_d.w = 3'h1;
         if (s_q.opc == OP_TWO_LINE_WR) s_d.w = 3'h2;
         if (s_q.opc == OP_FOUR_LINE_WR) s_d.w = 3'h4;
         if (s_q.wd_full) begin
            s_d.tx = {s_q.wd, 16'h0};
            s_d.wd_full = 1'b0;
         end else begin
            s_d.st = H_WAIT;
         end
      end
      if (done) begin
         s_d.st = H_END;
         s_d.csn = 1'b1;
      end
      case (s_d.w)
         3'h4: s_d.io = s_d.tx[23:20];
         3'h2: s_d.io = {2'b00, s_d.tx[23:22]};
         default: s_d.io = {3'b000, s_d.tx[23]};
      endcase
      s_d.oe = 4'h0;
      if (!s_d.csn && !(s_d.seg == SG_DT && rdop)) begin
         s_d.oe = {s_d.w[2], s_d.w[2], s_d.w[2] | s_d.w[1], 1'b1};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         s_q <= '0;
         s_q.csn <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign prdata_o = s_q.prd;
   assign pready_o = s_q.rdy;
   assign pslverr_o = s_q.err;
   assign lnk.cs_n = s_q.csn;
   assign lnk.sclk = s_q.sck;
   assign lnk.h_io = s_q.io;
   assign lnk.h_oe = s_q.oe;
endmodule

// file: rtl/mio_if.sv
// Purpose: Serial flash link between host and device
// Assumes: Undriven data lines float high
// Notes: Line level resolved from the two enables
`timescale 1ns/1ns
interface mio_if;
   logic cs_n;
   logic sclk;
   logic [3:0] h_io;
   logic [3:0] h_oe;
   logic [3:0] d_io;
   logic [3:0] d_oe;
   logic [3:0] io;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         io[i] = d_oe[i] ? d_io[i] : (h_oe[i] ? h_io[i] : 1'b1);
      end
   end
   modport dev (input cs_n, input sclk, input io,
                output d_io, output d_oe);
   modport host (output cs_n, output sclk, output h_io,
                 output h_oe, input io);
endinterface

// file: rtl/mio_pkg.sv
// Purpose: Shared constants for the multi-line flash link
// Assumes: One system clock of 250 MHz on both ends
// Notes: Host register offsets are byte addresses on APB
package mio_pkg;
   // ****************************************
   // Commands
   // ****************************************
   localparam logic [7:0] OP_WREN = 8'h06;
   localparam logic [7:0] OP_RDSR = 8'h05;
   localparam logic [7:0] OP_PAGE_WR = 8'h02;
   localparam logic [7:0] OP_TWO_LINE_WR = 8'ha2;
   localparam logic [7:0] OP_FOUR_LINE_WR = 8'h32;
   localparam logic [7:0] OP_OTP_ERASE = 8'h44;
   localparam logic [7:0] OP_OTP_WRITE = 8'h42;
   localparam logic [7:0] OP_OTP_READ = 8'h48;
   // ****************************************
   // Geometry and status
   // ****************************************
   localparam int PAGE_BYTES = 256;
   localparam int AREA_BYTES = 1024;
   localparam int AREA_CNT = 3;
   localparam logic [7:0] AREA_HI = 8'h00;
   localparam logic [3:0] AREA_SEL_MIN = 4'h1;
   localparam logic [3:0] AREA_SEL_MAX = 4'h3;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_WEL_BIT = 1;
   localparam logic [7:0] ERASED = 8'hff;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_NS = 4;
   localparam logic [3:0] SCLK_HALF_CYC = 4'h8;
   // ****************************************
   // Host registers
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_LEN = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0c;
   localparam logic [7:0] REG_RDATA = 8'h10;
   localparam logic [7:0] REG_STAT = 8'h14;
   localparam int CTRL_GO_BIT = 8;
endpackage

// file: sim/mio_asserts.sv
// Purpose: Link and status checks for both ends
// Assumes: Busy lengths given in system clocks
// Notes: Watches mio_if lines and device status
`timescale 1ns/1ns
module mio_asserts #(
   parameter int SE_CYC = 2000,
   parameter int PP_CYC = 100
) (
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic [3:0] d_io,
   input wire logic [3:0] d_oe,
   input wire logic [3:0] h_oe,
   input wire logic busy_flag_o,
   input wire logic write_enable_latch_o
);
   // ****
   // Busy length counter
   // ****
   logic [15:0] blen_q;
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !busy_flag_o) begin
         blen_q <= 16'h0;
      end else begin
         blen_q <= blen_q + 16'h1;
      end
   end
   sequence s_busy_start;
      $rose(busy_flag_o);
   endsequence
   sequence s_busy_end;
      $fell(busy_flag_o);
   endsequence
   // ****
   // Checks
   // ****
   a_sclk_idle: assert property (cs_n |-> !sclk)
      else $error("sclk high while deselected");
   a_so_only: assert property (d_oe[3:2] == 2'h0 && !d_oe[0])
      else $error("device drives a line other than io1");
   a_no_clash: assert property (!(d_oe[1] && h_oe[1]))
      else $error("host and device both drive io1");
   a_so_quiet: assert property (cs_n [*8] |-> !d_oe[1])
      else $error("device drives io1 while deselected");
   a_so_on_fall: assert property (
      $rose(sclk) && d_oe[1] |=> $stable(d_io[1]) [*6])
      else $error("read data changed after rising sclk");
   a_busy_after_cs: assert property (s_busy_start |-> cs_n)
      else $error("busy set while selected");
   a_wel_after_cs: assert property (
      $rose(write_enable_latch_o) |-> cs_n)
      else $error("latch set while selected");
   a_wel_clr_end: assert property (
      s_busy_end |-> ##[0:4] !write_enable_latch_o)
      else $error("latch not cleared after busy");
   a_busy_len: assert property (s_busy_end |->
      (blen_q >= PP_CYC - 1 && blen_q <= PP_CYC + 1) ||
      (blen_q >= SE_CYC - 1 && blen_q <= SE_CYC + 1))
      else $error("busy length wrong");
endmodule

// file: sim/tb_multi_io_program_and_otp_regs.sv
// Purpose: Self-checking bench, host and device joined
// Assumes: Host registers at package offsets
// Notes: Short erase and program times
`timescale 1ns/1ns
module tb_multi_io_program_and_otp_regs;
   import mio_pkg::*;
   localparam int SE_NS = 8000;
   localparam int PP_NS = 400;
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] paddr = 8'h0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [2:0] lock = 3'h0;
   logic [4:0] prot = 5'h0;
   logic qe = 1'b0;
   logic busy;
   logic write_enable_latch;
   int err_total = 0;
   int comparisons = 0;
   mio_if lnk ();
   always #2 clk_sys_i = ~clk_sys_i;
   mio_host mio_host_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .lnk(lnk));
   mio_dev #(.SE_TIME_NS(SE_NS), .PP_TIME_NS(PP_NS)) mio_dev_inst (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .otp_area_lock_bits_i(lock), .protect_field_i(prot),
      .quad_lines_enable_i(qe), .busy_flag_o(busy),
      .write_enable_latch_o(write_enable_latch), .lnk(lnk));
   mio_asserts #(.SE_CYC(SE_NS / CLK_NS), .PP_CYC(PP_NS / CLK_NS))
      mio_asserts_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .cs_n(lnk.cs_n), .sclk(lnk.sclk), .d_io(lnk.d_io),
      .d_oe(lnk.d_oe), .h_oe(lnk.h_oe), .busy_flag_o(busy),
      .write_enable_latch_o(write_enable_latch));
   // ****
   // Common tasks
   // ****
   task automatic final_report;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic tmo(input string nm);
      err_total++;
      $display("CHECK FAILED %s expected done seen timeout", nm);
      final_report();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      int n;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys_i);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pready !== 1'b1 && n < 5000);
      if (n >= 5000) tmo("pready");
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic go(input logic [7:0] op, input logic [23:0] a,
                     input logic [11:0] n);
      wr(REG_ADDR, {8'h0, a});
      wr(REG_LEN, {20'h0, n});
      wr(REG_CTRL, {24'h0, op} | (32'h1 << CTRL_GO_BIT));
   endtask
   task automatic idle;
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0, s);
         n++;
      end while (s[0] !== 1'b0 && n < 2000);
      if (n >= 2000) tmo("active");
   endtask
   task automatic bsy(input logic e);
      logic seen;
      int n;
      seen = 1'b0;
      repeat (20) begin
         @(posedge clk_sys_i);
         if (busy === 1'b1) seen = 1'b1;
      end
      chk("busy seen", {31'h0, e}, {31'h0, seen});
      n = 0;
      while (busy !== 1'b0 && n < 3000) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n >= 3000) tmo("busy");
   endtask
   task automatic wren;
      int n;
      go(OP_WREN, 24'h0, 12'h0);
      idle();
      n = 0;
      while (write_enable_latch !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk("latch", 32'h1, {31'h0, write_enable_latch});
   endtask
   task automatic rdb(output logic [7:0] b);
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STAT, 32'h0, s);
         n++;
      end while (s[2] !== 1'b1 && n < 2000);
      if (n >= 2000) tmo("rd_full");
      apb(1'b0, REG_RDATA, 32'h0, s);
      b = s[7:0];
   endtask
   task automatic send(input int n);
      for (int i = 0; i < n; i++) begin
         wr(REG_WDATA, 32'h5a ^ i);
      end
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_regs;
      logic [31:0] r;
      apb(1'b0, 8'h20, 32'h0, r);
      chk("unmapped err", 32'h1, {31'h0, pslverr});
      chk("unmapped data", 32'h0, r);
   endtask
   task automatic t_erase;
      go(OP_OTP_ERASE, 24'h001000, 12'h0);
      idle();
      bsy(1'b0);
      wren();
      go(OP_OTP_ERASE, 24'h004000, 12'h0);
      idle();
      bsy(1'b0);
      go(OP_OTP_ERASE, 24'h001000, 12'h0);
      idle();
      bsy(1'b1);
      chk("latch", 32'h0, {31'h0, write_enable_latch});
   endtask
   task automatic t_otp;
      logic [7:0] b;
      wren();
      go(OP_OTP_WRITE, 24'h0013fe, 12'h2);
      wr(REG_WDATA, 32'ha5);
      wr(REG_WDATA, 32'h3c);
      idle();
      bsy(1'b1);
      go(OP_OTP_READ, 24'h0013fe, 12'h3);
      rdb(b);
      chk("rd0", 32'ha5, {24'h0, b});
      rdb(b);
      chk("rd1", 32'h3c, {24'h0, b});
      rdb(b);
      chk("rd wrap", 32'hff, {24'h0, b});
      idle();
   endtask
   task automatic t_lock;
      logic [7:0] b;
      lock <= 3'b001;
      wren();
      go(OP_OTP_ERASE, 24'h001000, 12'h0);
      idle();
      bsy(1'b0);
      go(OP_OTP_WRITE, 24'h001000, 12'h1);
      send(1);
      idle();
      bsy(1'b0);
      go(OP_OTP_ERASE, 24'h002000, 12'h0);
      idle();
      go(OP_OTP_READ, 24'h0013fe, 12'h1);
      rdb(b);
      chk("rd busy", 32'hff, {24'h0, b});
      idle();
      go(OP_RDSR, 24'h0, 12'h1);
      rdb(b);
      chk("status", 32'h03, {24'h0, b});
      idle();
      bsy(1'b1);
      go(OP_OTP_READ, 24'h0013ff, 12'h1);
      rdb(b);
      chk("rd locked", 32'h3c, {24'h0, b});
      idle();
   endtask
   task automatic t_page;
      wren();
      go(OP_FOUR_LINE_WR, 24'h000010, 12'h1);
      send(1);
      idle();
      bsy(1'b0);
      qe <= 1'b1;
      prot <= 5'h01;
      go(OP_FOUR_LINE_WR, 24'h000010, 12'h1);
      send(1);
      idle();
      bsy(1'b0);
      prot <= 5'h00;
      go(OP_FOUR_LINE_WR, 24'h0000fe, 12'h3);
      send(3);
      idle();
      bsy(1'b1);
      chk("pb fe", 32'h5a, {24'h0, mio_dev_inst.pbuf_m[8'hfe]});
      chk("pb wrap", 32'h58, {24'h0, mio_dev_inst.pbuf_m[8'h00]});
      go(OP_TWO_LINE_WR, 24'h000100, 12'h2);
      send(2);
      idle();
      bsy(1'b0);
      wren();
      go(OP_TWO_LINE_WR, 24'h000100, 12'h2);
      send(2);
      idle();
      bsy(1'b1);
      chk("pb 01", 32'h5b, {24'h0, mio_dev_inst.pbuf_m[8'h01]});
      wren();
      go(OP_PAGE_WR, 24'h000205, 12'h1);
      send(1);
      idle();
      bsy(1'b1);
      chk("pb 05", 32'h5a, {24'h0, mio_dev_inst.pbuf_m[8'h05]});
   endtask
   initial begin
      repeat (4) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      repeat (4) @(posedge clk_sys_i);
      t_regs();
      t_erase();
      t_otp();
      t_lock();
      t_page();
      final_report();
   end
endmodule
